// File: common/csb_pkg.sv
// Shared constants and types of the compare, skip and branch unit
package csb_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W   = 16;
    localparam int OFS_W  = 7;
    localparam int ADDR_W = 8;
    localparam int BIT_W  = 3;

    // Bit positions inside the flag register
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_H = 3'h5;

    // Register map, byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h08;
    localparam int                CTRL_EN    = 0;
    localparam logic              CTRL_EN_RST = 1'h1;

    // Program counter steps
    localparam logic [PC_W-1:0] SKIP_SHORT = 16'h0002;
    localparam logic [PC_W-1:0] SKIP_LONG  = 16'h0003;
    localparam logic [PC_W-1:0] BR_STEP    = 16'h0001;

    // Extra wait cycles loaded before the final cycle
    localparam logic [1:0] WAIT_TWO   = 2'h0;
    localparam logic [1:0] WAIT_THREE = 2'h1;

    typedef enum logic [4:0] {
        OP_NONE       = 5'h00,
        OP_CMP        = 5'h01,
        OP_CMPC       = 5'h02,
        OP_CMPI       = 5'h03,
        OP_COMPARE_SKIP_EQUAL       = 5'h04,
        OP_SKIP_RCLR  = 5'h05,
        OP_SKIP_RSET  = 5'h06,
        OP_SKIP_IOCLR = 5'h07,
        OP_SKIP_IOSET = 5'h08,
        OP_BR_SET     = 5'h09,
        OP_BR_CLR     = 5'h0a,
        OP_BR_EQ      = 5'h0b,
        OP_BR_NE      = 5'h0c,
        OP_BR_CS      = 5'h0d,
        OP_BR_CC      = 5'h0e,
        OP_BR_SH      = 5'h0f,
        OP_BR_LO      = 5'h10,
        OP_BR_MI      = 5'h11,
        OP_BR_PL      = 5'h12,
        OP_BR_GE      = 5'h13,
        OP_BR_LT      = 5'h14,
        OP_BR_HS      = 5'h15,
        OP_BR_HC      = 5'h16
    } csb_op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } csb_state_type;
endpackage : csb_pkg

// File: common/csb_alu_if.sv
// Operand and flag bundle between the unit and its subtractor
`timescale 1ns/1ps
interface csb_alu_if;
    logic [7:0] lhs;
    logic [7:0] rhs;
    logic       borrowIn;
    logic       chainZero;
    logic       zero;
    logic       neg;
    logic       ovf;
    logic       carry;
    logic       half;
    modport user (output lhs, rhs, borrowIn, chainZero,
                  input  zero, neg, ovf, carry, half);
    modport alu  (input  lhs, rhs, borrowIn, chainZero,
                  output zero, neg, ovf, carry, half);
endinterface : csb_alu_if

// File: rtl/csb_sub_flags.sv
// Eight-bit subtractor that only produces flags
`timescale 1ns/1ps
module csb_sub_flags (
    csb_alu_if.alu alu
);
    logic [8:0] wide;
    logic [7:0] diff;

    always_comb begin
        wide = {1'b0, alu.lhs} - {1'b0, alu.rhs} - {8'h00, alu.borrowIn};
        diff = wide[7:0];
        // Zero chains through a multi-byte compare
        alu.zero  = (diff == 8'h00) && alu.chainZero;
        alu.neg   = diff[7];
        alu.ovf   = (alu.lhs[7] & ~alu.rhs[7] & ~diff[7]) |
                    (~alu.lhs[7] & alu.rhs[7] & diff[7]);
        alu.carry = (~alu.lhs[7] & alu.rhs[7]) | (alu.rhs[7] & diff[7]) |
                    (diff[7] & ~alu.lhs[7]);
        alu.half  = (~alu.lhs[3] & alu.rhs[3]) | (alu.rhs[3] & diff[3]) |
                    (diff[3] & ~alu.lhs[3]);
    end
endmodule : csb_sub_flags

// File: rtl/csb_unit.sv
// Compare, conditional skip and conditional branch execution unit
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// What this block does
// RQ1: Register compare subtracts the second register from the first, keeps no result, sets Z N V C H in one cycle.
// RQ2: Compare with carry also subtracts the carry, keeps no result, sets Z N V C H in one cycle.
// RQ3: Constant compare subtracts an encoded constant, keeps no result, sets Z N V C H in one cycle.
// RQ4: Compare-and-skip steps the counter by 2 or 3 when both registers match, no flags, 1 to 3 cycles.
// RQ5: Register bit clear skip jumps over the next instruction when the bit is zero, no flags.
// RQ6: Register bit set skip jumps over the next instruction when the bit is one, no flags.
// RQ7: I/O bit clear skip jumps over the next instruction when the I/O bit is zero, no flags.
// RQ8: I/O bit set skip jumps over the next instruction when the I/O bit is one, no flags.
// RQ9: Branch on flag set loads counter plus offset plus one when the chosen flag is one.
// RQ10: Branch on flag clear loads counter plus offset plus one when the chosen flag is zero.
// RQ11: Equal branch needs Z one and not-equal branch needs Z zero, flags untouched.
// RQ12: Carry-set and lower branches need C one, carry-clear and same-or-higher need C zero.
// RQ13: Negative branch needs N one and positive branch needs N zero.
// RQ14: Signed greater-or-equal needs N xor V zero, signed less-than needs it one.
// RQ15: Half-carry set and clear branches test H, flags untouched.
// RQ16: A failed branch ends in one cycle and a taken branch in two.
// RQ17: A skip takes one cycle untaken, two over a one-word and three over a two-word instruction.
module csb_unit
    import csb_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              issueValid,
    input  wire csb_op_type        issueOp,
    input  wire logic [7:0]        rdVal,
    input  wire logic [7:0]        rrVal,
    input  wire logic [7:0]        immK,
    input  wire logic [7:0]        ioVal,
    input  wire logic [BIT_W-1:0]  bitSel,
    input  wire logic [OFS_W-1:0]  offsetK,
    input  wire logic [PC_W-1:0]   pc,
    input  wire logic [7:0]        flagsIn,
    input  wire logic              nextTwoWord,
    output logic                   busy,
    output logic                   done,
    output logic                   flagsWe,
    output logic [7:0]             flagsOut,
    output logic                   pcLoad,
    output logic [PC_W-1:0]        pcTarget,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    typedef struct packed {
        csb_state_type  state;
        logic [1:0]     cnt;
        logic           busy;
        logic           done;
        logic           flagsWe;
        logic [7:0]     flagsOut;
        logic           pcLoad;
        logic [PC_W-1:0] pcTarget;
        logic           enable;
        logic [15:0]    takenCount;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
    } csb_regs_type;

    csb_regs_type q;
    csb_regs_type d;
    csb_alu_if    aluBus ();

    logic            issueFire;
    logic            isCmp;
    logic            isSkip;
    logic            isBranch;
    logic            skipCond;
    logic            brCond;
    logic [PC_W-1:0] offsetExt;

    csb_sub_flags u_sub (
        .alu (aluBus.alu)
    );

    assign offsetExt = {{(PC_W-OFS_W){offsetK[OFS_W-1]}}, offsetK};

    always_comb begin
        d = q;
        d.done    = 1'b0;
        d.pcLoad  = 1'b0;
        d.flagsWe = 1'b0;
        // Disabled unit ignores the issue strobe
        issueFire = issueValid && q.state == ST_IDLE && q.enable;
        isCmp    = issueOp == OP_CMP || issueOp == OP_CMPC || issueOp == OP_CMPI;
        isSkip   = issueOp inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_RCLR, OP_SKIP_RSET,
                                   OP_SKIP_IOCLR, OP_SKIP_IOSET};
        isBranch = issueOp inside {[OP_BR_SET:OP_BR_HC]};

        aluBus.lhs       = rdVal;
        aluBus.rhs       = (issueOp == OP_CMPI) ? immK : rrVal; // see RQ3
        aluBus.borrowIn  = (issueOp == OP_CMPC) && flagsIn[FLAG_C]; // see RQ2
        aluBus.chainZero = (issueOp == OP_CMPC) ? flagsIn[FLAG_Z] : 1'b1;

        case (issueOp)
            OP_COMPARE_SKIP_EQUAL:       skipCond = rdVal == rrVal;     // see RQ4
            OP_SKIP_RCLR:  skipCond = !rrVal[bitSel];     // see RQ5
            OP_SKIP_RSET:  skipCond = rrVal[bitSel];      // see RQ6
            OP_SKIP_IOCLR: skipCond = !ioVal[bitSel];     // see RQ7
            OP_SKIP_IOSET: skipCond = ioVal[bitSel];      // see RQ8
            default:       skipCond = 1'b0;
        endcase

        case (issueOp)
            OP_BR_SET: brCond = flagsIn[bitSel];                 // see RQ9
            OP_BR_CLR: brCond = !flagsIn[bitSel];                // see RQ10
            OP_BR_EQ:  brCond = flagsIn[FLAG_Z];                 // see RQ11
            OP_BR_NE:  brCond = !flagsIn[FLAG_Z];                // see RQ11
            OP_BR_CS,
            OP_BR_LO:  brCond = flagsIn[FLAG_C];                 // see RQ12
            OP_BR_CC,
            OP_BR_SH:  brCond = !flagsIn[FLAG_C];                // see RQ12
            OP_BR_MI:  brCond = flagsIn[FLAG_N];                 // see RQ13
            OP_BR_PL:  brCond = !flagsIn[FLAG_N];                // see RQ13
            // Taken from N and V, not a stored sign bit
            OP_BR_GE:  brCond = !(flagsIn[FLAG_N] ^ flagsIn[FLAG_V]); // see RQ14
            OP_BR_LT:  brCond = flagsIn[FLAG_N] ^ flagsIn[FLAG_V];    // see RQ14
            OP_BR_HS:  brCond = flagsIn[FLAG_H];                 // see RQ15
            OP_BR_HC:  brCond = !flagsIn[FLAG_H];                // see RQ15
            default:   brCond = 1'b0;
        endcase

        case (q.state)
            ST_IDLE: begin
                if (issueFire && isCmp) begin
                    d.done    = 1'b1;
                    d.flagsWe = 1'b1; // see RQ1
                    d.flagsOut = flagsIn;
                    d.flagsOut[FLAG_Z] = aluBus.zero;
                    d.flagsOut[FLAG_N] = aluBus.neg;
                    d.flagsOut[FLAG_V] = aluBus.ovf;
                    d.flagsOut[FLAG_C] = aluBus.carry;
                    d.flagsOut[FLAG_H] = aluBus.half;
                end else if (issueFire && isSkip) begin
                    if (skipCond) begin
                        d.state = ST_WAIT;
                        d.busy  = 1'b1;
                        d.cnt   = nextTwoWord ? WAIT_THREE : WAIT_TWO; // see RQ17
                        d.pcTarget = pc + (nextTwoWord ? SKIP_LONG : SKIP_SHORT); // see RQ4
                        d.takenCount = q.takenCount + 16'h0001;
                    end else begin
                        d.done = 1'b1; // see RQ17
                    end
                end else if (issueFire && isBranch) begin
                    if (brCond) begin
                        d.state = ST_WAIT;
                        d.busy  = 1'b1;
                        d.cnt   = WAIT_TWO; // see RQ16
                        d.pcTarget = pc + offsetExt + BR_STEP; // see RQ9
                        d.takenCount = q.takenCount + 16'h0001;
                    end else begin
                        d.done = 1'b1; // see RQ16
                    end
                end else if (issueFire) begin
                    d.done = 1'b1;
                end
            end
            ST_WAIT: begin
                if (q.cnt == WAIT_TWO) begin
                    d.state  = ST_IDLE;
                    d.busy   = 1'b0;
                    d.done   = 1'b1;
                    d.pcLoad = 1'b1; // see RQ16
                end else begin
                    d.cnt = q.cnt - 2'h1;
                end
            end
            default: begin
                d.state = ST_IDLE;
                d.busy  = 1'b0;
            end
        endcase

        // APB slave, zero wait states, answer prepared in the setup cycle
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && !penable && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            case (paddr)
                REG_CTRL:   d.prdata[CTRL_EN] = q.enable;
                REG_STATUS: d.prdata = {16'h0000, q.flagsOut, 7'h00, q.busy};
                REG_COUNT:  d.prdata = {16'h0000, q.takenCount};
                default:    d.pslverr = 1'b1;
            endcase
        end
        // Only the control word is writable; the others ignore writes
        if (psel && penable && q.pready && pwrite && paddr == REG_CTRL) begin
            d.enable = pwdata[CTRL_EN];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '{state: ST_IDLE, cnt: 2'h0, busy: 1'b0, done: 1'b0,
                   flagsWe: 1'b0, flagsOut: 8'h00, pcLoad: 1'b0,
                   pcTarget: 16'h0000,
                   enable: CTRL_EN_RST, takenCount: 16'h0000,
                   prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign busy     = q.busy;
    assign done     = q.done;
    assign flagsWe  = q.flagsWe;
    assign flagsOut = q.flagsOut;
    assign pcLoad   = q.pcLoad;
    assign pcTarget = q.pcTarget;
    assign prdata   = q.prdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic accept;
    assign accept = issueValid && !busy && q.enable;

    sequence finishNoLoad;
        done && !pcLoad && !flagsWe;
    endsequence
    sequence twoCycleLoad;
        busy && !done ##1 done && pcLoad && !flagsWe;
    endsequence
    sequence threeCycleLoad;
        busy && !done ##1 busy && !done ##1 done && pcLoad;
    endsequence

    cmp_zero_flag_a: assert property ( // see RQ1
        accept && issueOp == OP_CMP |=> done && flagsWe &&
            flagsOut[FLAG_Z] == ($past(rdVal) == $past(rrVal)))
        else $error("compare zero flag wrong");
    cmpc_borrow_a: assert property ( // see RQ2
        accept && issueOp == OP_CMPC && flagsIn[FLAG_C] && rdVal == rrVal
            |=> flagsWe && flagsOut[FLAG_C] && !flagsOut[FLAG_Z])
        else $error("compare with carry borrow wrong");
    cmpi_carry_a: assert property ( // see RQ3
        accept && issueOp == OP_CMPI |=> done && !pcLoad &&
            flagsOut[FLAG_C] == ($past(rdVal) < $past(immK)))
        else $error("constant compare carry wrong");
    compare_skip_equal_skip_a: assert property ( // see RQ4
        accept && issueOp == OP_COMPARE_SKIP_EQUAL && rdVal == rrVal && !nextTwoWord
            |=> twoCycleLoad ##0 pcTarget == $past(pc, 2) + SKIP_SHORT)
        else $error("compare skip target wrong");
    skip_long_a: assert property ( // see RQ17
        accept && isSkip && skipCond && nextTwoWord
            |=> threeCycleLoad ##0 pcTarget == $past(pc, 3) + SKIP_LONG)
        else $error("two-word skip timing wrong");
    skip_untaken_a: assert property ( // see RQ5
        accept && issueOp == OP_SKIP_RCLR && rrVal[bitSel] |=> finishNoLoad)
        else $error("bit clear skip taken on one");
    io_skip_a: assert property ( // see RQ8
        accept && issueOp == OP_SKIP_IOSET && ioVal[bitSel] && !nextTwoWord
            |=> twoCycleLoad)
        else $error("io bit set skip not taken");
    br_taken_a: assert property ( // see RQ9
        accept && issueOp == OP_BR_SET && flagsIn[bitSel] |=> twoCycleLoad ##0
            pcTarget == $past(pc, 2) + $past(offsetExt, 2) + BR_STEP)
        else $error("taken branch target wrong");
    br_fall_a: assert property ( // see RQ16
        accept && isBranch && !brCond |=> finishNoLoad)
        else $error("untaken branch not one cycle");
    signed_ge_a: assert property ( // see RQ14
        accept && issueOp == OP_BR_GE &&
            (flagsIn[FLAG_N] ^ flagsIn[FLAG_V]) |=> finishNoLoad)
        else $error("signed branch taken wrongly");
    skip_rset_a: assert property ( // see RQ6
        accept && issueOp == OP_SKIP_RSET && !rrVal[bitSel] |=> finishNoLoad)
        else $error("bit set skip taken on zero");
    io_clear_a: assert property ( // see RQ7
        accept && issueOp == OP_SKIP_IOCLR && !ioVal[bitSel] && !nextTwoWord
            |=> twoCycleLoad ##0 pcTarget == $past(pc, 2) + SKIP_SHORT)
        else $error("io bit clear skip not taken");
    br_clear_a: assert property ( // see RQ10
        accept && issueOp == OP_BR_CLR && !flagsIn[bitSel] |=> twoCycleLoad ##0
            pcTarget == $past(pc, 2) + $past(offsetExt, 2) + BR_STEP)
        else $error("flag clear branch target wrong");
    br_equal_a: assert property ( // see RQ11
        accept && (issueOp == OP_BR_EQ && !flagsIn[FLAG_Z] ||
            issueOp == OP_BR_NE && flagsIn[FLAG_Z]) |=> finishNoLoad)
        else $error("zero flag branch taken wrongly");
    br_carry_a: assert property ( // see RQ12
        accept && issueOp inside {OP_BR_CS, OP_BR_LO} && flagsIn[FLAG_C]
            |=> twoCycleLoad)
        else $error("carry branch not taken");
    br_minus_a: assert property ( // see RQ13
        accept && issueOp == OP_BR_PL && flagsIn[FLAG_N] |=> finishNoLoad)
        else $error("positive branch taken on negative");
    br_half_a: assert property ( // see RQ15
        accept && issueOp == OP_BR_HC && !flagsIn[FLAG_H] |=> twoCycleLoad ##0
            flagsOut == $past(flagsOut, 2))
        else $error("half carry branch wrong");
    off_ignore_a: assert property (
        issueValid && !busy && !q.enable |=> !done && !busy)
        else $error("disabled unit took an instruction");
    apb_answer_a: assert property (
        psel && !penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one cycle");
endmodule : csb_unit

// File: verification/csb_unit_test.sv
// Self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ps
module csb_unit_test
    import csb_pkg::*;
;
    logic              mclk        = 1'b0;
    logic              reset       = 1'b1;
    logic              issueValid  = 1'b0;
    csb_op_type        issueOp     = OP_NONE;
    logic [7:0]        rdVal       = 8'h00;
    logic [7:0]        rrVal       = 8'h00;
    logic [7:0]        immK        = 8'h00;
    logic [7:0]        ioVal       = 8'h00;
    logic [BIT_W-1:0]  bitSel      = 3'h0;
    logic [OFS_W-1:0]  offsetK     = 7'h00;
    logic [PC_W-1:0]   pc          = 16'h0000;
    logic [7:0]        flagsIn     = 8'h00;
    logic              nextTwoWord = 1'b0;
    logic              psel        = 1'b0;
    logic              penable     = 1'b0;
    logic              pwrite      = 1'b0;
    logic [ADDR_W-1:0] paddr       = 8'h00;
    logic [31:0]       pwdata      = 32'h0;
    logic              busy, done, flagsWe, pcLoad, pready, pslverr;
    logic [7:0]        flagsOut;
    logic [PC_W-1:0]   pcTarget;
    logic [31:0]       prdata;
    logic [31:0]       rdData;
    logic              err;
    logic [15:0]       pcVal       = 16'h0000;
    logic [7:0]        lastFlags   = 8'h00;
    logic [7:0]        va [5]      = '{8'h00, 8'h80, 8'h10, 8'h7f, 8'h3c};
    logic [7:0]        vb [5]      = '{8'h01, 8'h01, 8'h01, 8'hff, 8'h3c};
    logic [7:0]        fl [3]      = '{8'h00, 8'h2b, 8'h0c};
    int                badCount    = 0;
    int                checked     = 0;
    int                cycles      = 0;
    int                expCount    = 0;
    int                m;

    always #12.5 mclk = ~mclk;

    csb_unit csb_unit_i (.mclk(mclk), .reset(reset), .issueValid(issueValid),
        .issueOp(issueOp), .rdVal(rdVal), .rrVal(rrVal), .immK(immK), .ioVal(ioVal),
        .bitSel(bitSel), .offsetK(offsetK), .pc(pc), .flagsIn(flagsIn),
        .nextTwoWord(nextTwoWord), .busy(busy), .done(done), .flagsWe(flagsWe),
        .flagsOut(flagsOut), .pcLoad(pcLoad), .pcTarget(pcTarget), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic closeOut;
        $display("Mismatches %0d, comparisons %0d", badCount, checked);
        if (badCount == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : closeOut

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        // Look between edges; the closing edge sees the same settled answer
        do begin
            @(negedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdData = prdata;
        err = pslverr;
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) badCount++;
    endtask : apb

    function automatic logic [7:0] cmpFlags(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic chain,
                                            input logic [7:0] f);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] o;
        r = {1'b0, a} - {1'b0, b} - 9'(cin);
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin);
        o = f;
        o[FLAG_C] = r[8];
        o[FLAG_H] = h[4];
        o[FLAG_N] = r[7];
        o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        o[FLAG_Z] = (r[7:0] == 8'h00) && (!chain || f[FLAG_Z]);
        return o;
    endfunction : cmpFlags

    // Issues one instruction and judges its cycles, counter load and flags
    task automatic run(input csb_op_type op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] f, input logic [2:0] s, input logic [6:0] k,
                       input logic two);
        int n;
        logic tk;
        logic sk;
        logic cmp;
        logic [7:0] ef;
        logic [15:0] tgt;
        @(posedge mclk);
        rdVal <= a;
        rrVal <= b;
        immK <= b;
        ioVal <= b;
        flagsIn <= f;
        bitSel <= s;
        offsetK <= k;
        nextTwoWord <= two;
        pc <= pcVal;
        issueOp <= op;
        issueValid <= 1'b1;
        @(posedge mclk);
        issueValid <= 1'b0;
        case (op)
            OP_COMPARE_SKIP_EQUAL:                tk = (a == b);
            OP_SKIP_RCLR, OP_SKIP_IOCLR: tk = !b[s];
            OP_SKIP_RSET, OP_SKIP_IOSET: tk = b[s];
            OP_BR_SET:              tk = f[s];
            OP_BR_CLR:              tk = !f[s];
            OP_BR_EQ:               tk = f[FLAG_Z];
            OP_BR_NE:               tk = !f[FLAG_Z];
            OP_BR_CS, OP_BR_LO:     tk = f[FLAG_C];
            OP_BR_CC, OP_BR_SH:     tk = !f[FLAG_C];
            OP_BR_MI:               tk = f[FLAG_N];
            OP_BR_PL:               tk = !f[FLAG_N];
            OP_BR_GE:               tk = !(f[FLAG_N] ^ f[FLAG_V]);
            OP_BR_LT:               tk = f[FLAG_N] ^ f[FLAG_V];
            OP_BR_HS:               tk = f[FLAG_H];
            OP_BR_HC:               tk = !f[FLAG_H];
            default:                tk = 1'b0;
        endcase
        sk = op inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_RCLR, OP_SKIP_RSET, OP_SKIP_IOCLR, OP_SKIP_IOSET};
        cmp = op inside {OP_CMP, OP_CMPC, OP_CMPI};
        ef = cmpFlags(a, b, (op == OP_CMPC) & f[FLAG_C], op == OP_CMPC, f);
        tgt = sk ? pcVal + (two ? SKIP_LONG : SKIP_SHORT)
                 : pcVal + 16'({{9{k[6]}}, k}) + BR_STEP;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (done !== 1'b1 && n < 6);
        check(32'(n), !tk ? 32'd1 : (sk && two) ? 32'd3 : 32'd2);
        check(32'(pcLoad), 32'(tk));
        if (tk) check(32'(pcTarget), 32'(tgt));
        check(32'(flagsWe), 32'(cmp));
        if (cmp) lastFlags = ef;
        check(32'(flagsOut), 32'(lastFlags));
        if (tk) expCount++;
    endtask : run

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            badCount++;
            closeOut();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        check(32'({busy, done, flagsOut}), 32'h0);
        apb(1'b0, REG_CTRL, 32'h0);
        check(rdData, 32'(CTRL_EN_RST));
        for (int o = 1; o <= 3; o++)
            for (int i = 0; i < 10; i++)
                run(csb_op_type'(o), va[i/2], vb[i/2], i[0] ? 8'hff : 8'h00,
                    3'h0, 7'h00, 1'b0);
        pcVal = 16'hfffe;
        for (int o = 4; o <= 8; o++)
            for (int s = 0; s < 8; s++)
                run(csb_op_type'(o), s[0] ? 8'ha5 : 8'h5a, 8'ha5, 8'h3f,
                    3'(s), 7'h00, s[1]);
        pcVal = 16'h0010;
        for (int o = 9; o <= 22; o++)
            for (int j = 0; j < 3; j++)
                run(csb_op_type'(o), 8'h00, 8'h00, fl[j], 3'(o + j),
                    j[0] ? 7'h40 : 7'h3f, 1'b0);
        // Disabled unit must ignore an offered instruction
        apb(1'b1, REG_CTRL, 32'h0);
        @(posedge mclk);
        issueOp <= OP_BR_NE;
        flagsIn <= 8'h00;
        issueValid <= 1'b1;
        m = 0;
        repeat (4) begin
            @(negedge mclk);
            if (done !== 1'b0 || busy !== 1'b0) m++;
        end
        @(posedge mclk);
        issueValid <= 1'b0;
        check(32'(m), 32'd0);
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b1, REG_COUNT, 32'h0);
        apb(1'b0, REG_COUNT, 32'h0);
        check(rdData, 32'(expCount));
        apb(1'b0, REG_STATUS, 32'h0);
        check(rdData, {16'h0000, lastFlags, 8'h00});
        apb(1'b0, 8'h0c, 32'h0);
        check({rdData[30:0], err}, 32'h1);
        run(OP_BR_EQ, 8'h00, 8'h00, 8'h02, 3'h0, 7'h01, 1'b0);
        // Unknown opcode ends in one cycle with no load and no flag write
        run(OP_NONE, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
        closeOut();
    end
endmodule : csb_unit_test
